// [pkg/pwmdps_regs.vh]
// Purpose: Register map, field positions and reset values of the
//          three-channel duty/period PWM timebase.
// Assumes: Avalon-MM word addressing, one 8-bit register per word.
// Notes:   Definitions only; included by bare name.
`ifndef PWMDPS_REGS_VH
`define PWMDPS_REGS_VH

// ----------------------------------------------------------------
// Word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PWMDPS_REG_CTRL     4'h0
`define PWMDPS_REG_SYNC     4'h1
`define PWMDPS_REG_DUTY0_LO 4'h2
`define PWMDPS_REG_PER_LO   4'h8
`define PWMDPS_REG_PER_HI   4'h9
`define PWMDPS_REG_CNT_LO   4'hA
`define PWMDPS_REG_CNT_HI   4'hB
`define PWMDPS_REG_IRQ_STAT 4'hC
`define PWMDPS_REG_IRQ_MASK 4'hD
`define PWMDPS_DUTY_STRIDE  4'h2

// ----------------------------------------------------------------
// Main control register fields
// ----------------------------------------------------------------
`define PWMDPS_CTRL_RELOAD  0
`define PWMDPS_CTRL_ISEL_LO 1
`define PWMDPS_CTRL_ISEL_HI 2
`define PWMDPS_CTRL_ON      3
`define PWMDPS_CTRL_PCK_LO  4
`define PWMDPS_CTRL_PCK_HI  5
`define PWMDPS_CTRL_CENTER  7

// ----------------------------------------------------------------
// Sync control register fields
// ----------------------------------------------------------------
`define PWMDPS_SYNC_MIRROR  0
`define PWMDPS_SYNC_EN      1
`define PWMDPS_SYNC_REQ     2
`define PWMDPS_SYNC_W       4

// ----------------------------------------------------------------
// Interrupt status and mask layout
// ----------------------------------------------------------------
`define PWMDPS_IRQ_PERIOD   0
`define PWMDPS_IRQ_SYNC     1
`define PWMDPS_IRQ_DUTY_LO  2
`define PWMDPS_IRQ_DUTY_HI  4
`define PWMDPS_IRQ_W        5

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define PWMDPS_CTRL_RST     8'h00
`define PWMDPS_SYNC_RST     4'h0
`define PWMDPS_IRQ_RST      5'h00
`define PWMDPS_VAL_RST      10'h000
`define PWMDPS_VAL_ONE      10'h001
`define PWMDPS_DIV_RST      3'h0
`define PWMDPS_RDATA_RST    32'h0000_0000

// ----------------------------------------------------------------
// Byte split of ten-bit values and high-byte word step
// ----------------------------------------------------------------
`define PWMDPS_HI_OFS       4'h1
`define PWMDPS_VAL_LO       7:0
`define PWMDPS_VAL_HI       9:8
`define PWMDPS_BYTE_HI      1:0

// ----------------------------------------------------------------
// Prescaler codes and tick masks
// ----------------------------------------------------------------
`define PWMDPS_PCK_DIV1     2'h0
`define PWMDPS_PCK_DIV2     2'h1
`define PWMDPS_PCK_DIV4     2'h2
`define PWMDPS_MASK_DIV1    3'h0
`define PWMDPS_MASK_DIV2    3'h1
`define PWMDPS_MASK_DIV4    3'h3
`define PWMDPS_MASK_DIV8    3'h7

`endif

// [logic/pwmdps_top.v]
// Purpose: Three-channel 10-bit PWM timebase with shared period,
//          buffered duty values, synchronous update and mirroring.
// Assumes: One clock; Avalon-MM slave on the same clock; only byte
//          lane 0 carries register data.
// Notes:   Every access answers with waitrequest low one cycle after
//          the request is raised.
//          A sync request made while reload is clear stays pending and completes
//          at the first period end after reload is set; one made while sync enable is clear never completes.
//          The quick update bit is stored and read back only.
//          Write-only and unmapped words read as zero.
`include "pwmdps_regs.vh"

module pwmdps_top (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // PWM outputs and interrupt
  output wire [2:0]  pwmOut,
  output wire        irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0]               ctrl_reg;
  reg  [`PWMDPS_SYNC_W-1:0] sync_reg;
  reg  [9:0]               perBuf_reg;
  reg  [9:0]               perAct_reg;
  reg  [9:0]               cnt_reg;
  reg                      up_reg;
  reg  [2:0]               div_reg;
  reg  [`PWMDPS_IRQ_W-1:0] irqStat_reg;
  reg  [`PWMDPS_IRQ_W-1:0] irqStat_next;
  reg  [`PWMDPS_IRQ_W-1:0] irqMask_reg;
  reg                      irq_reg;
  reg                      wait_reg;
  reg  [31:0]              rdata_reg;
  reg  [31:0]              rdata_next;
  reg  [9:0]               cnt_next;
  reg                      up_next;
  reg  [2:0]               divMask;
  wire [2:0]               dutyHit;
  wire                     reloadOn;
  wire                     blockOn;
  wire                     centerMode;
  wire [1:0]               irqSel;
  wire                     syncEn;
  wire                     mirrorOn;
  wire                     wrTake;
  wire [7:0]               wrData;
  wire                     tick;
  wire                     periodEnd;
  wire                     dutyLoad;
  wire                     syncDone;
  wire [`PWMDPS_IRQ_W-1:0] irqEvt;
  wire                     ctrlWr;
  wire                     syncWr;
  wire                     perLoWr;
  wire                     perHiWr;
  wire                     statWr;
  wire                     maskWr;
  wire                     duty0LoWr;
  wire                     duty0HiWr;

  // Control field decode
  // Sync and mirror are gated here, so both fall away when reload clears
  assign reloadOn   = ctrl_reg[`PWMDPS_CTRL_RELOAD];
  assign blockOn    = ctrl_reg[`PWMDPS_CTRL_ON];
  assign centerMode = ctrl_reg[`PWMDPS_CTRL_CENTER];
  assign irqSel     = ctrl_reg[`PWMDPS_CTRL_ISEL_HI:`PWMDPS_CTRL_ISEL_LO];
  assign syncEn     = sync_reg[`PWMDPS_SYNC_EN] & reloadOn;
  assign mirrorOn   = sync_reg[`PWMDPS_SYNC_MIRROR] & reloadOn;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Write lands at the edge where the master sees waitrequest low
  assign wrTake      = write & ~wait_reg & byteenable[0];
  assign wrData      = writedata[7:0];
  assign waitrequest = wait_reg;
  assign readdata    = rdata_reg;

  // Per-register write strobes; each fires only at the accepting edge
  assign ctrlWr    = wrTake & (address == `PWMDPS_REG_CTRL);
  assign syncWr    = wrTake & (address == `PWMDPS_REG_SYNC);
  assign perLoWr   = wrTake & (address == `PWMDPS_REG_PER_LO);
  assign perHiWr   = wrTake & (address == `PWMDPS_REG_PER_HI);
  assign statWr    = wrTake & (address == `PWMDPS_REG_IRQ_STAT);
  assign maskWr    = wrTake & (address == `PWMDPS_REG_IRQ_MASK);
  assign duty0LoWr = wrTake & (address == `PWMDPS_REG_DUTY0_LO);
  assign duty0HiWr = wrTake & (address == `PWMDPS_REG_DUTY0_LO + `PWMDPS_HI_OFS);

  // Waitrequest drops for one cycle per request, then rises again
  // A request held past its answer is taken as a new one and answered again
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((read | write) & wait_reg);
    end
  end

  // Read mux; write-only and unmapped words read as zero
  always @* begin
    rdata_next = `PWMDPS_RDATA_RST;
    case (address)
      `PWMDPS_REG_CTRL:     rdata_next[7:0] = ctrl_reg;
      `PWMDPS_REG_SYNC:     rdata_next[`PWMDPS_SYNC_W-1:0] = sync_reg;
      `PWMDPS_REG_CNT_LO:   rdata_next[`PWMDPS_VAL_LO] = cnt_reg[`PWMDPS_VAL_LO];
      `PWMDPS_REG_CNT_HI:   rdata_next[`PWMDPS_BYTE_HI] = cnt_reg[`PWMDPS_VAL_HI];
      `PWMDPS_REG_IRQ_STAT: rdata_next[`PWMDPS_IRQ_W-1:0] = irqStat_reg;
      `PWMDPS_REG_IRQ_MASK: rdata_next[`PWMDPS_IRQ_W-1:0] = irqMask_reg;
      default:              rdata_next = `PWMDPS_RDATA_RST;
    endcase
  end

  // Capture read data while waitrequest is still high
  // The answer comes from this register, so readdata leaves a flop directly
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= `PWMDPS_RDATA_RST;
    end else if (read & wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Main control: mode, prescale, on/off, irq select, reload
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `PWMDPS_CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_reg <= wrData;
    end
  end

  // Sync control; a fresh software write beats the hardware clear
  // Only the request bit is cleared by hardware; the others stay put
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_reg <= `PWMDPS_SYNC_RST;
    end else if (syncWr) begin
      sync_reg <= wrData[`PWMDPS_SYNC_W-1:0];
    end else if (syncDone) begin
      sync_reg[`PWMDPS_SYNC_REQ] <= 1'b0;
    end
  end

  // Period buffer, written byte by byte
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      perBuf_reg <= `PWMDPS_VAL_RST;
    end else if (perLoWr) begin
      perBuf_reg[`PWMDPS_VAL_LO] <= wrData;
    end else if (perHiWr) begin
      perBuf_reg[`PWMDPS_VAL_HI] <= wrData[`PWMDPS_BYTE_HI];
    end
  end

  // Active period: follows the buffer unless reload defers it
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      perAct_reg <= `PWMDPS_VAL_RST;
    end else if (!reloadOn || !blockOn || periodEnd) begin
      perAct_reg <= perBuf_reg;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  // Divider mask for sys, /2, /4, /8
  always @* begin
    case (ctrl_reg[`PWMDPS_CTRL_PCK_HI:`PWMDPS_CTRL_PCK_LO])
      `PWMDPS_PCK_DIV1: divMask = `PWMDPS_MASK_DIV1;
      `PWMDPS_PCK_DIV2: divMask = `PWMDPS_MASK_DIV2;
      `PWMDPS_PCK_DIV4: divMask = `PWMDPS_MASK_DIV4;
      default:          divMask = `PWMDPS_MASK_DIV8;
    endcase
  end

  // One tick per prescaled clock; nothing ticks while the block is off
  assign tick = blockOn & ((div_reg & divMask) == divMask);

  // Divider is held at zero while off so the first tick is aligned
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= `PWMDPS_DIV_RST;
    end else if (!blockOn) begin
      div_reg <= `PWMDPS_DIV_RST;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // Next count; a zero period is illegal but still kept bounded
  always @* begin
    cnt_next = cnt_reg;
    up_next  = up_reg;
    if (!centerMode) begin
      up_next = 1'b1;
      if (cnt_reg >= perAct_reg) begin
        cnt_next = `PWMDPS_VAL_RST;
      end else begin
        cnt_next = cnt_reg + `PWMDPS_VAL_ONE;
      end
    end else if (up_reg) begin
      if (cnt_reg < perAct_reg) begin
        cnt_next = cnt_reg + `PWMDPS_VAL_ONE;
      end else if (perAct_reg <= `PWMDPS_VAL_ONE) begin
        cnt_next = `PWMDPS_VAL_RST;
      end else begin
        cnt_next = perAct_reg - `PWMDPS_VAL_ONE;
        up_next  = 1'b0;
      end
    end else begin
      if (cnt_reg <= `PWMDPS_VAL_ONE) begin
        cnt_next = `PWMDPS_VAL_RST;
        up_next  = 1'b1;
      end else begin
        cnt_next = cnt_reg - `PWMDPS_VAL_ONE;
      end
    end
  end

  // A period ends on the tick that returns the count to zero
  // Reloads, the period event and sync completion all share this point
  assign periodEnd = tick & (cnt_next == `PWMDPS_VAL_RST);

  // Counter and direction; stopping clears the count
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= `PWMDPS_VAL_RST;
      up_reg  <= 1'b1;
    end else if (!blockOn) begin
      cnt_reg <= `PWMDPS_VAL_RST;
      up_reg  <= 1'b1;
    end else if (tick) begin
      cnt_reg <= cnt_next;
      up_reg  <= up_next;
    end
  end

  // ----------------------------------------------------------------
  // Duty reload control
  // ----------------------------------------------------------------
  // With sync enabled, duties wait for a request so all three move at once
  // With reload on and the block running, period end is the only load point, so no channel runs a mixed set
  assign dutyLoad = periodEnd & (~syncEn | sync_reg[`PWMDPS_SYNC_REQ]);
  assign syncDone = periodEnd & syncEn & sync_reg[`PWMDPS_SYNC_REQ];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // One channel per pass; word indices are worked out wide, then cut
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : gen_ch
      localparam [31:0] LO_WIDE = `PWMDPS_REG_DUTY0_LO + `PWMDPS_DUTY_STRIDE * i;
      localparam [3:0]  LO_IDX  = LO_WIDE[3:0];
      localparam [3:0]  HI_IDX  = LO_IDX + `PWMDPS_HI_OFS;
      reg  [9:0] buf_reg;
      reg  [9:0] act_reg;
      reg        out_reg;
      wire       loWr;
      wire       hiWr;
      wire       mirLo;
      wire       mirHi;

      // Channel 0 writes are copied here only while mirroring
      assign mirLo = (i != 0) & mirrorOn & duty0LoWr;
      assign mirHi = (i != 0) & mirrorOn & duty0HiWr;
      assign loWr  = (wrTake & (address == LO_IDX)) | mirLo;
      assign hiWr  = (wrTake & (address == HI_IDX)) | mirHi;

      // Duty buffer, low and high bytes
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          buf_reg <= `PWMDPS_VAL_RST;
        end else begin
          if (loWr) begin
            buf_reg[`PWMDPS_VAL_LO] <= wrData;
          end
          if (hiWr) begin
            buf_reg[`PWMDPS_VAL_HI] <= wrData[`PWMDPS_BYTE_HI];
          end
        end
      end

      // Active duty; immediate without reload, else at period end
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          act_reg <= `PWMDPS_VAL_RST;
        end else if (!reloadOn || !blockOn || dutyLoad) begin
          act_reg <= buf_reg;
        end
      end

      // High while the count is below duty: D ticks edge, 2D-1 center
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          out_reg <= 1'b0;
        end else begin
          out_reg <= blockOn & (cnt_reg < act_reg);
        end
      end

      // Center duty match, filtered by direction select
      assign dutyHit[i] = tick & centerMode & (cnt_reg == act_reg) &
                          ((up_reg & irqSel[0]) | (~up_reg & irqSel[1]));
      assign pwmOut[i]  = out_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Event layout: period end, sync done, then one duty match per channel
  assign irqEvt = {dutyHit, syncDone, periodEnd};

  // Write one to clear; a same-cycle event keeps its bit set
  always @* begin
    irqStat_next = irqStat_reg;
    if (statWr) begin
      irqStat_next = irqStat_reg & ~wrData[`PWMDPS_IRQ_W-1:0];
    end
    irqStat_next = irqStat_next | irqEvt;
  end

  // Status, mask and registered interrupt level
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irqStat_reg <= `PWMDPS_IRQ_RST;
      irqMask_reg <= `PWMDPS_IRQ_RST;
      irq_reg     <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      if (maskWr) begin
        irqMask_reg <= wrData[`PWMDPS_IRQ_W-1:0];
      end
      irq_reg <= |(irqStat_reg & irqMask_reg);
    end
  end

  // Level output, one clock behind status and mask
  assign irq = irq_reg;

endmodule // pwmdps_top

// [verif/pwmdps_top_props.sv]
// Purpose: Concurrent checks on the PWM timebase ports.
// Assumes: One clock, async active-high reset, one-cycle bus answer.
// Notes:   Shadows of the on bit and mask track bus writes only.
`include "pwmdps_regs.vh"

module pwmdps_props (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Avalon-MM slave
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Outputs
  input wire [2:0]  pwmOut,
  input wire        irq
);
  logic ctrlOn_reg;
  logic maskZero_reg;
  wire  wrDone = write && !waitrequest && byteenable[0];

  // ----------------------------------------------------------------
  // Shadow state, updated at the edge a write takes effect
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlOn_reg   <= 1'b0;
      maskZero_reg <= 1'b1;
    end else if (wrDone && address == `PWMDPS_REG_CTRL) begin
      ctrlOn_reg <= writedata[`PWMDPS_CTRL_ON];
    end else if (wrDone && address == `PWMDPS_REG_IRQ_MASK) begin
      maskZero_reg <= (writedata[4:0] == 5'h00);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Bus timing and read-back values
  // ----------------------------------------------------------------
  property p_wait_answer; $rose(read || write) |=> !waitrequest; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer one cycle after request");
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
  property p_upper_zero; read && !waitrequest |-> readdata[31:8] == 24'h00_0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_hi_zero; read && !waitrequest && address == `PWMDPS_REG_CNT_HI |-> readdata[7:2] == 6'h00; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("counter high byte spare bits set");
  property p_wo_zero;
    read && !waitrequest && address >= `PWMDPS_REG_DUTY0_LO && address <= `PWMDPS_REG_PER_HI |-> readdata == 32'h0000_0000;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only register read nonzero");
  property p_sync_rsvd; read && !waitrequest && address == `PWMDPS_REG_SYNC |-> readdata[7:4] == 4'h0; endproperty
  a_sync_rsvd: assert property (p_sync_rsvd) else $error("sync register spare bits set");

  // ----------------------------------------------------------------
  // Off state and interrupt masking; two cycles allowed for pipeline lag
  // ----------------------------------------------------------------
  property p_off_quiet; !ctrlOn_reg && !$past(ctrlOn_reg) && !$past(ctrlOn_reg, 2) |-> pwmOut == 3'b000; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("outputs active while block off");
  property p_off_count;
    read && !waitrequest && address == `PWMDPS_REG_CNT_LO && !ctrlOn_reg && !$past(ctrlOn_reg, 2) |-> readdata[7:0] == 8'h00;
  endproperty
  a_off_count: assert property (p_off_count) else $error("counter nonzero while block off");
  property p_irq_masked; maskZero_reg && $past(maskZero_reg) && $past(maskZero_reg, 2) |-> !irq; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt high with all bits masked");
endmodule // pwmdps_props

bind pwmdps_top pwmdps_props u_props (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .pwmOut(pwmOut), .irq(irq));

// [verif/tb_pwm_duty_period_sync.sv]
// Purpose: Self-checking bench for the PWM timebase.
// Assumes: 50 ns clock; bus answer is awaited, never assumed.
// Notes:   High times are counted over whole periods in steady state.
`include "pwmdps_regs.vh"

module tb_pwm_duty_period_sync;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, read, write, waitrequest, irq;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [2:0]  pwmOut;
  int          badCount, cmpCount;

  pwmdps_top dut_u (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pwmOut(pwmOut), .irq(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (badCount == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= 32'(d);
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 20 && waitrequest !== 1'b0) begin
      badCount++;
      $display("Error at %0t: bus answer timed out", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    access(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [3:0] a);
    access(1'b0, a, 8'h00, q);
  endtask

  // Split ten-bit value: low byte, then bits 9:8 in the high byte
  task automatic put10(input logic [3:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, {6'h00, v[9:8]});
  endtask

  task automatic duties(input logic [9:0] d0, input logic [9:0] d1, input logic [9:0] d2);
    put10(4'h2, d0);
    put10(4'h4, d1);
    put10(4'h6, d2);
  endtask

  // Settle, then count high cycles of each channel over n clocks
  task automatic measure(input int n, input int e0, input int e1, input int e2);
    int h[3];
    h = '{0, 0, 0};
    repeat (40) @(posedge clk);
    repeat (n) begin
      @(negedge clk);
      for (int i = 0; i < 3; i++) if (pwmOut[i] === 1'b1) h[i]++;
    end
    check(h[0], e0);
    check(h[1], e1);
    check(h[2], e2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(`PWMDPS_REG_CNT_LO); check(q, 32'h0000_0000);
    rd(`PWMDPS_REG_CNT_HI); check(q, 32'h0000_0000);
    rd(`PWMDPS_REG_SYNC);   check(q, 32'h0000_0000);
    rd(`PWMDPS_REG_DUTY0_LO); check(q, 32'h0000_0000);
    rd(4'hE);               check(q, 32'h0000_0000);
  endtask

  // Edge mode with high-byte values: 261-tick period, then prescale by two
  task automatic t_edge();
    put10(`PWMDPS_REG_PER_LO, 10'h104);
    duties(10'h102, 10'h000, 10'h081);
    wr(`PWMDPS_REG_CTRL, 8'h08);
    measure(522, 516, 0, 258);
    wr(`PWMDPS_REG_CTRL, 8'h18);
    measure(1044, 1032, 0, 516);
    rd(`PWMDPS_REG_CNT_HI); check(q & 32'hFFFF_FFFC, 32'h0000_0000);
  endtask

  // Center mode: period 8, active 2d-1; duty at the peak matches only counting up
  task automatic t_center();
    put10(`PWMDPS_REG_PER_LO, 10'h004);
    duties(10'h002, 10'h001, 10'h004);
    wr(`PWMDPS_REG_CTRL, 8'h88);
    measure(80, 30, 10, 70);
    for (int s = 0; s < 4; s++) begin
      wr(`PWMDPS_REG_CTRL, 8'h88 | 8'(s << 1));
      wr(`PWMDPS_REG_IRQ_STAT, 8'h1F);
      repeat (20) @(posedge clk);
      rd(`PWMDPS_REG_IRQ_STAT);
      check(q & 32'h0000_001C, (s == 0) ? 32'h0000_0000 : (s == 2) ? 32'h0000_000C : 32'h0000_001C);
    end
  endtask

  // Reload on: mirror, held buffers, then one synchronous update
  task automatic t_sync();
    put10(`PWMDPS_REG_PER_LO, 10'h004);
    wr(`PWMDPS_REG_CTRL, 8'h09);
    wr(`PWMDPS_REG_SYNC, 8'h01);
    put10(4'h2, 10'h003);
    measure(50, 30, 30, 30);
    wr(`PWMDPS_REG_SYNC, 8'h02);
    duties(10'h001, 10'h002, 10'h004);
    measure(50, 30, 30, 30);
    wr(`PWMDPS_REG_SYNC, 8'h06);
    for (int n = 0; n < 20; n++) begin
      rd(`PWMDPS_REG_SYNC);
      if (q[`PWMDPS_SYNC_REQ] === 1'b0) break;
    end
    check(q, 32'h0000_0002);
    rd(`PWMDPS_REG_IRQ_STAT); check(q[`PWMDPS_IRQ_SYNC], 1'b1);
    measure(50, 10, 20, 40);
    wr(`PWMDPS_REG_CTRL, 8'h08);
    put10(4'h2, 10'h002);
    measure(50, 20, 20, 40);
  endtask

  // Interrupt raise, mask, clear; block switched off
  task automatic t_irq_off();
    wr(`PWMDPS_REG_IRQ_MASK, 8'h01);
    repeat (20) @(posedge clk);
    check(irq, 1'b1);
    wr(`PWMDPS_REG_CTRL, 8'h00);
    wr(`PWMDPS_REG_IRQ_STAT, 8'h1F);
    repeat (3) @(negedge clk);
    check(irq, 1'b0);
    check(pwmOut, 3'b000);
    rd(`PWMDPS_REG_CNT_LO); check(q, 32'h0000_0000);
    rd(`PWMDPS_REG_IRQ_STAT); check(q, 32'h0000_0000);
    wr(`PWMDPS_REG_IRQ_MASK, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = 4'h0;
    writedata = 32'h0000_0000; byteenable = 4'hF; badCount = 0; cmpCount = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_edge();
    t_center();
    t_sync();
    t_irq_off();
    conclude();
  end
endmodule // tb_pwm_duty_period_sync
